/* File: rtl/power_query_smart.sv */
// Task-file command handler for the power-mode query and failure-prediction commands.
// Assumes the host drives one-cycle read and write strobes synchronous to clk_i,
// and that firmware supplies the power mode, attribute samples and nonvolatile settings.
`timescale 1ns/1ns
`include "pq_consts.svh"
module power_query_smart #(
    parameter int   NUM_ATTR    = 30,
    parameter logic DEV_SEL     = 1'b0,
    parameter int   TICK_CYCLES = `TICK_CYCLES,
    parameter int   SAVE_TICKS  = `AUTOSAVE_TICKS
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // Task-file access
    input  wire pq_pkg::host_bus_t        host_i,
    output logic [7:0]                    rdata_o,
    output logic                          intrq_o,
    // Data-out stream
    output pq_pkg::xfer_t                 xfer_o,
    input  wire logic                     xfer_ready_i,
    // Drive condition
    input  wire pq_pkg::pwr_mode_t        pwr_mode_i,
    // Attribute sampling
    input  wire logic                     sample_valid_i,
    input  wire logic [4:0]               sample_idx_i,
    input  wire logic [7:0]               sample_val_i,
    input  wire logic [NUM_ATTR-1:0][7:0] thresh_i,
    // Nonvolatile settings
    input  wire logic                     nv_predict_i,
    input  wire logic                     nv_autosave_i,
    output logic                          nv_wr_o,
    output logic                          nv_predict_o,
    output logic                          nv_autosave_o
);
    import pq_pkg::*;

    ctl_t       r_reg;
    ctl_t       r_next;
    logic       save_req;
    logic       auto_fire;
    logic       attr_fail;
    logic [7:0] attr_byte;
    logic [7:0] status_byte;
    logic [7:0] pwr_code;
    logic       keys_ok;
    logic       abort;
    logic       go_xfer;
    logic       go_thr;

    attr_store #(
        .NUM_ATTR (NUM_ATTR)
    ) u_store (
        .clk_i          (clk_i),
        .rst_n_i        (rst_n_i),
        .upd_en_i       (r_reg.predict_en),
        .sample_valid_i (sample_valid_i),
        .sample_idx_i   (sample_idx_i),
        .sample_val_i   (sample_val_i),
        .thresh_i       (thresh_i),
        .save_i         (save_req | auto_fire),
        .rd_thr_i       (r_reg.xfer_thr),
        .rd_idx_i       (r_reg.xfer_idx),
        .byte_o         (attr_byte),
        .fail_o         (attr_fail)
    );

    // timer runs only with prediction on
    autosave_timer #(
        .TICK_CYCLES (TICK_CYCLES),
        .SAVE_TICKS  (SAVE_TICKS)
    ) u_timer (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (r_reg.predict_en & r_reg.autosave_en),
        .restart_i (save_req),
        .fire_o    (auto_fire)
    );

    always_comb begin
        case (pwr_mode_i)
            PWR_STANDBY: pwr_code = `PWR_CODE_STANDBY;
            PWR_IDLE:    pwr_code = `PWR_CODE_IDLE;
            PWR_ACTIVE:  pwr_code = `PWR_CODE_ACTIVE;
            default:     pwr_code = `PWR_CODE_ACTIVE;
        endcase
    end

    always_comb begin
        status_byte               = `ZERO_BYTE;
        status_byte[`STAT_BSY]    = r_reg.bsy;
        status_byte[`STAT_RDY]    = ~r_reg.bsy;
        status_byte[`STAT_DRQ]    = r_reg.drq;
        status_byte[`STAT_ERR]    = r_reg.err;
    end

    assign keys_ok = (r_reg.key_lo == `KEY_LOW) && (r_reg.key_hi == `KEY_HIGH);

    always_comb begin
        r_next       = r_reg;
        r_next.nv_wr = 1'b0;
        save_req     = 1'b0;
        abort        = 1'b0;
        go_xfer      = 1'b0;
        go_thr       = 1'b0;

        // settings come back from nonvolatile storage after reset.
        if (!r_reg.nv_loaded) begin
            r_next.nv_loaded   = 1'b1;
            r_next.predict_en  = nv_predict_i;
            r_next.autosave_en = nv_autosave_i;
        end

        if (host_i.rd) begin
            case (host_i.addr)
                `OFF_FEATURE:    r_next.rdata = r_reg.fault;
                `OFF_COUNT:      r_next.rdata = r_reg.count;
                `OFF_SECTOR:     r_next.rdata = r_reg.sector;
                `OFF_KEY_LOW:    r_next.rdata = r_reg.key_lo;
                `OFF_KEY_HIGH:   r_next.rdata = r_reg.key_hi;
                `OFF_DRIVE_HEAD: r_next.rdata = r_reg.drive_head;
                `OFF_COMMAND: begin
                    r_next.rdata = status_byte;
                    r_next.intrq = 1'b0;
                end
                default:         r_next.rdata = `ZERO_BYTE;
            endcase
        end

        // Writes during busy are dropped so a running command sees stable inputs.
        if (host_i.wr && !r_reg.bsy) begin
            case (host_i.addr)
                `OFF_FEATURE:    r_next.feature    = host_i.wdata;
                `OFF_COUNT:      r_next.count      = host_i.wdata;
                `OFF_SECTOR:     r_next.sector     = host_i.wdata;
                `OFF_KEY_LOW:    r_next.key_lo     = host_i.wdata;
                `OFF_KEY_HIGH:   r_next.key_hi     = host_i.wdata;
                `OFF_DRIVE_HEAD: r_next.drive_head = host_i.wdata;
                `OFF_COMMAND: begin
                    if (r_reg.drive_head[`UNIT_SEL_BIT] == DEV_SEL) begin
                        r_next.opcode  = host_i.wdata;
                        r_next.bsy     = 1'b1;
                        r_next.drq     = 1'b0;
                        r_next.err     = 1'b0;
                        r_next.fault   = `ZERO_BYTE;
                        r_next.xfer    = '0;
                        r_next.state   = ST_EXEC;
                    end
                end
                default: ;
            endcase
        end

        case (r_reg.state)
            ST_IDLE: ;
            ST_EXEC: begin
                case (r_reg.opcode)
                    `OP_PWR_QUERY_A, `OP_PWR_QUERY_B: begin
                        r_next.count = pwr_code;
                    end
                    `OP_PREDICT: begin
                        if (!keys_ok) begin
                            abort = 1'b1;
                        end else if (!r_reg.predict_en && r_reg.feature != `SUB_ENABLE) begin
                            abort = 1'b1;
                        end else begin
                            case (r_reg.feature)
                                `SUB_RD_ATTR: begin
                                    save_req = 1'b1;
                                    go_xfer  = 1'b1;
                                end
                                `SUB_RD_THRESH: begin
                                    go_xfer = 1'b1;
                                    go_thr  = 1'b1;
                                end
                                `SUB_AUTOSAVE: begin
                                    r_next.autosave_en = (r_reg.count != `ZERO_BYTE);
                                    r_next.nv_wr       = 1'b1;
                                end
                                `SUB_SAVE: begin
                                    save_req = 1'b1;
                                end
                                `SUB_ENABLE: begin
                                    r_next.predict_en = 1'b1;
                                    r_next.nv_wr      = 1'b1;
                                end
                                `SUB_DISABLE: begin
                                    r_next.predict_en = 1'b0;
                                    r_next.nv_wr      = 1'b1;
                                end
                                `SUB_STATUS: begin
                                    save_req = 1'b1;
                                    if (attr_fail) begin
                                        r_next.key_lo = `FAIL_KEY_LOW;
                                        r_next.key_hi = `FAIL_KEY_HIGH;
                                    end else begin
                                        r_next.key_lo = `KEY_LOW;
                                        r_next.key_hi = `KEY_HIGH;
                                    end
                                end
                                default: abort = 1'b1;
                            endcase
                        end
                    end
                    default: abort = 1'b1;
                endcase
                if (abort) begin
                    r_next.fault[`FAULT_ABORT] = 1'b1;
                    r_next.err                 = 1'b1;
                end
                if (go_xfer) begin
                    // The saved copy settles this edge, so the first byte loads next cycle.
                    r_next.state    = ST_XFER;
                    r_next.bsy      = 1'b0;
                    r_next.drq      = 1'b1;
                    r_next.intrq    = 1'b1;
                    r_next.xfer_idx = '0;
                    r_next.xfer_thr = go_thr;
                end else begin
                    r_next.state = ST_DONE;
                end
            end
            ST_DONE: begin
                r_next.bsy   = 1'b0;
                r_next.intrq = 1'b1;
                r_next.state = ST_IDLE;
            end
            ST_XFER: begin
                if (r_reg.xfer.valid && xfer_ready_i && r_reg.xfer_idx == `BLOCK_BYTES) begin
                    r_next.xfer.valid = 1'b0;
                    r_next.drq        = 1'b0;
                    r_next.state      = ST_IDLE;
                end else if (!r_reg.xfer.valid || xfer_ready_i) begin
                    r_next.xfer.valid = 1'b1;
                    r_next.xfer.data  = attr_byte;
                    r_next.xfer_idx   = r_reg.xfer_idx + 10'h001;
                end
            end
            default: r_next.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rdata_o       = r_reg.rdata;
    assign intrq_o       = r_reg.intrq;
    assign xfer_o        = r_reg.xfer;
    assign nv_wr_o       = r_reg.nv_wr;
    assign nv_predict_o  = r_reg.predict_en;
    assign nv_autosave_o = r_reg.autosave_en;

endmodule : power_query_smart

/* File: pkg/pq_consts.svh */
// Constants for the power-mode query and failure-prediction command handler.
// Assumes a 100 MHz device clock and a host writing the task-file registers.
`ifndef PQ_CONSTS_SVH
`define PQ_CONSTS_SVH

`define OFF_FEATURE      16'h01F1
`define OFF_COUNT        16'h01F2
`define OFF_SECTOR       16'h01F3
`define OFF_KEY_LOW      16'h01F4
`define OFF_KEY_HIGH     16'h01F5
`define OFF_DRIVE_HEAD   16'h01F6
`define OFF_COMMAND      16'h01F7

`define OP_PWR_QUERY_A   8'h98
`define OP_PWR_QUERY_B   8'hE5
`define OP_PREDICT       8'hB0

`define SUB_RD_ATTR      8'hD0
`define SUB_RD_THRESH    8'hD1
`define SUB_AUTOSAVE     8'hD2
`define SUB_SAVE         8'hD3
`define SUB_ENABLE       8'hD8
`define SUB_DISABLE      8'hD9
`define SUB_STATUS       8'hDA

`define KEY_LOW          8'h4F
`define KEY_HIGH         8'hC2
`define FAIL_KEY_LOW     8'hF4
`define FAIL_KEY_HIGH    8'h2C

`define PWR_CODE_STANDBY 8'h00
`define PWR_CODE_IDLE    8'h80
`define PWR_CODE_ACTIVE  8'hFF
`define ZERO_BYTE        8'h00

`define STAT_BSY         7
`define STAT_RDY         6
`define STAT_DRQ         3
`define STAT_ERR         0
`define FAULT_ABORT      2
`define UNIT_SEL_BIT     4

`define BLOCK_BYTES      10'h200

`define CLK_PERIOD_NS    10
`define TICK_NS          1000000
`define TICK_CYCLES      (`TICK_NS / `CLK_PERIOD_NS)
`define AUTOSAVE_MIN     15
`define MS_PER_MIN       60000
`define AUTOSAVE_TICKS   (`AUTOSAVE_MIN * `MS_PER_MIN)

`endif

/* File: pkg/pq_pkg.sv */
// Types shared by the command handler and its host-facing ports.
// Assumes pq_consts.svh supplies all numeric constants.
package pq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DONE = 2'b11,
        ST_XFER = 2'b10
    } pq_state_t;

    typedef enum logic [1:0] {
        PWR_STANDBY = 2'b00,
        PWR_IDLE    = 2'b01,
        PWR_ACTIVE  = 2'b10
    } pwr_mode_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } host_bus_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } xfer_t;

    typedef struct packed {
        pq_state_t  state;
        logic [7:0] feature;
        logic [7:0] fault;
        logic [7:0] count;
        logic [7:0] sector;
        logic [7:0] key_lo;
        logic [7:0] key_hi;
        logic [7:0] drive_head;
        logic [7:0] opcode;
        logic       bsy;
        logic       drq;
        logic       err;
        logic       intrq;
        logic       predict_en;
        logic       autosave_en;
        logic       nv_wr;
        logic       nv_loaded;
        logic [7:0] rdata;
        logic [9:0] xfer_idx;
        logic       xfer_thr;
        xfer_t      xfer;
    } ctl_t;

endpackage : pq_pkg

/* File: rtl/autosave_timer.sv */
// Interval timer that requests an attribute save after a fixed idle period.
// Assumes run_i drops whenever automatic saving is not allowed.
`timescale 1ns/1ns
`include "pq_consts.svh"
module autosave_timer #(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int SAVE_TICKS  = `AUTOSAVE_TICKS
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Control
    input  wire logic run_i,
    input  wire logic restart_i,
    output logic      fire_o
);
    localparam int DW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam int TW = $clog2(SAVE_TICKS + 1);
    localparam logic [DW-1:0] DIV_LAST  = DW'(TICK_CYCLES - 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(SAVE_TICKS);

    typedef struct packed {
        logic [DW-1:0] div;
        logic [TW-1:0] ticks;
        logic          fire;
    } tmr_t;

    tmr_t r_reg;
    tmr_t r_next;

    always_comb begin
        r_next      = r_reg;
        r_next.fire = 1'b0;
        if (!run_i || restart_i) begin
            r_next.div   = '0;
            r_next.ticks = '0;
        end else if (r_reg.div == DIV_LAST) begin
            r_next.div = '0;
            if (r_reg.ticks == TICK_LAST - TW'(1)) begin
                r_next.ticks = '0;
                r_next.fire  = 1'b1;
            end else begin
                r_next.ticks = r_reg.ticks + TW'(1);
            end
        end else begin
            r_next.div = r_reg.div + DW'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign fire_o = r_reg.fire;

endmodule : autosave_timer

/* File: rtl/attr_store.sv */
// Attribute value store: live values, saved copies and threshold comparison.
// Assumes thresholds arrive as a static vector from the drive firmware.
`timescale 1ns/1ns
`include "pq_consts.svh"
module attr_store #(
    parameter int NUM_ATTR = 30
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // Sampling
    input  wire logic                     upd_en_i,
    input  wire logic                     sample_valid_i,
    input  wire logic [4:0]               sample_idx_i,
    input  wire logic [7:0]               sample_val_i,
    input  wire logic [NUM_ATTR-1:0][7:0] thresh_i,
    // Save and readout
    input  wire logic                     save_i,
    input  wire logic                     rd_thr_i,
    input  wire logic [9:0]               rd_idx_i,
    output logic [7:0]                    byte_o,
    output logic                          fail_o
);
    typedef struct packed {
        logic [NUM_ATTR-1:0][7:0] live;
        logic [NUM_ATTR-1:0][7:0] saved;
    } store_t;

    store_t               r_reg;
    store_t               r_next;
    logic  [NUM_ATTR-1:0] below;

    always_comb begin
        r_next = r_reg;
        if (upd_en_i && sample_valid_i && (32'(sample_idx_i) < NUM_ATTR)) begin
            r_next.live[sample_idx_i] = sample_val_i;
        end
        if (save_i) begin
            r_next.saved = r_reg.live;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // A threshold of zero never trips, so unused slots stay quiet.
    for (genvar i = 0; i < NUM_ATTR; i++) begin : g_cmp
        assign below[i] = (r_reg.live[i] < thresh_i[i]);
    end
    assign fail_o = |below;

    always_comb begin
        byte_o = `ZERO_BYTE;
        if (32'(rd_idx_i) < NUM_ATTR) begin
            byte_o = rd_thr_i ? thresh_i[rd_idx_i] : r_reg.saved[rd_idx_i];
        end
    end

endmodule : attr_store

/* File: sim/pq_checker_assertions.sv */
// Port-level checks for the power query and prediction command handler.
// Assumes it is bound to power_query_smart and sees only that module's ports.
`timescale 1ns/1ns
`include "pq_consts.svh"
module pq_checker (
    // Clock and reset
    input wire logic              clk_i,
    input wire logic              rst_n_i,
    // Watched ports
    input wire pq_pkg::host_bus_t host_i,
    input wire logic [7:0]        rdata_o,
    input wire logic              intrq_o,
    input wire pq_pkg::xfer_t     xfer_o,
    input wire logic              xfer_ready_i,
    input wire logic              nv_wr_o
);
    import pq_pkg::*;
    logic       cmd_wr;
    logic       stat_rd;
    logic [9:0] beat_reg;
    assign cmd_wr  = host_i.wr && host_i.addr == `OFF_COMMAND;
    assign stat_rd = host_i.rd && host_i.addr == `OFF_COMMAND;
    // A refused command write would restart this count, so the bench never writes one mid-block.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            beat_reg <= 10'h000;
        end else if (cmd_wr) begin
            beat_reg <= 10'h000;
        end else if (xfer_o.valid && xfer_ready_i) begin
            beat_reg <= beat_reg + 10'h001;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    chk_xfer_hold: assert property (xfer_o.valid && !xfer_ready_i |=> xfer_o.valid && $stable(xfer_o.data))
        else $error("stream byte changed before it was taken");
    chk_block_len: assert property (xfer_o.valid |-> beat_reg < 10'h200)
        else $error("stream longer than one block");
    chk_xfer_start: assert property ($rose(xfer_o.valid) && beat_reg == 10'h000 |-> $past(cmd_wr, 3))
        else $error("stream started at the wrong cycle");
    chk_irq_origin: assert property ($rose(intrq_o) |-> $past(cmd_wr, 2) || $past(cmd_wr, 3))
        else $error("interrupt not tied to a command");
    chk_irq_hold: assert property (intrq_o && !stat_rd |=> intrq_o)
        else $error("interrupt dropped without a status read");
    chk_irq_clear: assert property (intrq_o && stat_rd && !$past(cmd_wr) && !$past(cmd_wr, 2) |=> !intrq_o)
        else $error("status read left interrupt set");
    chk_rdata_hold: assert property (!host_i.rd |=> $stable(rdata_o))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property (host_i.rd && (host_i.addr < `OFF_FEATURE || host_i.addr > `OFF_COMMAND)
        |=> rdata_o == `ZERO_BYTE)
        else $error("unmapped read not zero");
    chk_nv_pulse: assert property (nv_wr_o |=> !nv_wr_o)
        else $error("persist strobe longer than one cycle");
endmodule : pq_checker

bind power_query_smart pq_checker chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .host_i(host_i), .rdata_o(rdata_o), .intrq_o(intrq_o),
    .xfer_o(xfer_o), .xfer_ready_i(xfer_ready_i), .nv_wr_o(nv_wr_o));

/* File: sim/host_sink.sv */
// Host-side sink for the device's data-out stream.
// Assumes the bench clears it before each data command.
`timescale 1ns/1ns
module host_sink (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    // Control
    input  wire logic          clr_i,
    input  wire logic          slow_i,
    // Stream
    input  wire pq_pkg::xfer_t xfer_i,
    output logic               ready_o
);
    import pq_pkg::*;
    logic [7:0] mem [512];
    int         n_got;
    logic [1:0] pace_reg;
    // A slow host takes one byte in four, so the device must hold each byte meanwhile.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pace_reg <= 2'h0;
            ready_o  <= 1'b0;
            n_got    <= 0;
        end else begin
            pace_reg <= pace_reg + 2'h1;
            ready_o  <= !slow_i || pace_reg == 2'h3;
            if (clr_i) begin
                n_got <= 0;
            end else if (xfer_i.valid && ready_o) begin
                mem[n_got % 512] <= xfer_i.data;
                n_got            <= n_got + 1;
            end
        end
    end
endmodule : host_sink

/* File: sim/tb.sv */
// Self-checking bench for the power query and prediction command handler.
// Assumes the host_sink model on the stream and the bound port checker.
`timescale 1ns/1ns
`include "pq_consts.svh"
module tb;
    import pq_pkg::*;
    logic                clk_i, rst_n_i, sample_valid_i, nv_predict_i, nv_autosave_i, clr, slow, xfer_ready_i;
    logic                intrq_o, nv_wr_o, nv_predict_o, nv_autosave_o;
    host_bus_t           host;
    xfer_t               xfer_o;
    pwr_mode_t           pwr_mode_i;
    logic [4:0]          sample_idx_i;
    logic [7:0]          sample_val_i, rdata_o, rv, st;
    logic [29:0][7:0]    thresh_i;
    int                  n_fail, samples_checked;
    power_query_smart #(.TICK_CYCLES(4), .SAVE_TICKS(3)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .host_i(host),
        .rdata_o(rdata_o), .intrq_o(intrq_o), .xfer_o(xfer_o), .xfer_ready_i(xfer_ready_i),
        .pwr_mode_i(pwr_mode_i), .sample_valid_i(sample_valid_i), .sample_idx_i(sample_idx_i),
        .sample_val_i(sample_val_i), .thresh_i(thresh_i), .nv_predict_i(nv_predict_i),
        .nv_autosave_i(nv_autosave_i), .nv_wr_o(nv_wr_o), .nv_predict_o(nv_predict_o),
        .nv_autosave_o(nv_autosave_o));
    host_sink sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .clr_i(clr), .slow_i(slow), .xfer_i(xfer_o),
        .ready_o(xfer_ready_i));
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        host <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        host.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge clk_i);
        host <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        host.rd <= 1'b0;
        #1 rv = rdata_o;
    endtask : rd
    // Issues one command, waits for its interrupt and, for a block read, for all bytes.
    task automatic run(input logic [7:0] feat, input logic [7:0] op, input logic data);
        int i, j;
        clr <= 1'b1;
        wr(`OFF_FEATURE, feat);
        clr <= 1'b0;
        wr(`OFF_COMMAND, op);
        for (i = 0; i < 40 && intrq_o !== 1'b1; i++) @(posedge clk_i);
        for (j = 0; data && j < 5000 && sink.n_got < 512; j++) @(posedge clk_i);
        if (i >= 40 || j >= 5000) begin
            check("command completion", 16'h0001, 16'h0000);
            final_report();
        end
        if (data) check("block bytes", 16'h0200, 16'(sink.n_got));
        rd(`OFF_COMMAND);
        st = rv;
        check("interrupt cleared", 16'h0000, {15'h0, intrq_o});
    endtask : run
    task automatic abort_check(input logic [7:0] exp);
        check("status err", {8'h00, exp & 8'h01}, {8'h00, st & 8'h89});
        rd(`OFF_FEATURE);
        check("fault abort", {8'h00, exp & 8'h04}, {8'h00, rv & 8'h04});
    endtask : abort_check
    task automatic keys(input logic [7:0] lo, input logic [7:0] hi);
        wr(`OFF_KEY_LOW, lo);
        wr(`OFF_KEY_HIGH, hi);
    endtask : keys
    task automatic sample(input logic [4:0] idx, input logic [7:0] val);
        @(posedge clk_i);
        sample_valid_i <= 1'b1;
        sample_idx_i   <= idx;
        sample_val_i   <= val;
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
    endtask : sample
    task automatic reset_dev(input logic p, input logic a);
        rst_n_i       <= 1'b0;
        nv_predict_i  <= p;
        nv_autosave_i <= a;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask : reset_dev
    task automatic t_power;
        logic [7:0] code [3] = '{`PWR_CODE_STANDBY, `PWR_CODE_IDLE, `PWR_CODE_ACTIVE};
        rd(16'h01F0);
        check("unmapped", 16'h0000, {8'h00, rv});
        for (int m = 0; m < 3; m++) begin
            pwr_mode_i <= pwr_mode_t'(m);
            run(8'h00, m[0] ? `OP_PWR_QUERY_B : `OP_PWR_QUERY_A, 1'b0);
            abort_check(8'h00);
            rd(`OFF_COUNT);
            check("power code", {8'h00, code[m]}, {8'h00, rv});
        end
    endtask : t_power
    task automatic t_enable;
        keys(`KEY_LOW, `KEY_HIGH);
        run(`SUB_RD_ATTR, `OP_PREDICT, 1'b0);
        abort_check(8'h05);
        run(`SUB_ENABLE, `OP_PREDICT, 1'b0);
        abort_check(8'h00);
        check("predict on", 16'h0001, {15'h0, nv_predict_o});
        run(8'h55, `OP_PREDICT, 1'b0);
        abort_check(8'h05);
        keys(8'h00, `KEY_HIGH);
        run(`SUB_SAVE, `OP_PREDICT, 1'b0);
        abort_check(8'h05);
        keys(`KEY_LOW, 8'h00);
        run(`SUB_SAVE, `OP_PREDICT, 1'b0);
        abort_check(8'h05);
        keys(`KEY_LOW, `KEY_HIGH);
    endtask : t_enable
    task automatic t_settings;
        for (int c = 1; c >= 0; c--) begin
            wr(`OFF_COUNT, 8'(c));
            run(`SUB_AUTOSAVE, `OP_PREDICT, 1'b0);
            check("autosave", 16'(c), {15'h0, nv_autosave_o});
            sample(5'h02, 8'(c) + 8'h07);
            repeat (20) @(posedge clk_i);
            check("auto save", 16'h0008, {8'h00, dut.u_store.r_reg.saved[2]});
        end
        run(`SUB_SAVE, `OP_PREDICT, 1'b0);
        abort_check(8'h00);
        run(`SUB_DISABLE, `OP_PREDICT, 1'b0);
        check("predict off", 16'h0000, {15'h0, nv_predict_o});
        run(`SUB_SAVE, `OP_PREDICT, 1'b0);
        abort_check(8'h05);
        run(`SUB_ENABLE, `OP_PREDICT, 1'b0);
    endtask : t_settings
    task automatic t_status;
        thresh_i[0] <= 8'h33;
        thresh_i[1] <= 8'h10;
        sample(5'h00, 8'h40);
        sample(5'h01, 8'h20);
        run(`SUB_STATUS, `OP_PREDICT, 1'b0);
        rd(`OFF_KEY_LOW);
        check("healthy low", {8'h00, `KEY_LOW}, {8'h00, rv});
        sample(5'h01, 8'h05);
        run(`SUB_STATUS, `OP_PREDICT, 1'b0);
        rd(`OFF_KEY_LOW);
        check("failing low", {8'h00, `FAIL_KEY_LOW}, {8'h00, rv});
        rd(`OFF_KEY_HIGH);
        check("failing high", {8'h00, `FAIL_KEY_HIGH}, {8'h00, rv});
        keys(`KEY_LOW, `KEY_HIGH);
    endtask : t_status
    task automatic t_blocks;
        slow <= 1'b1;
        run(`SUB_RD_THRESH, `OP_PREDICT, 1'b1);
        check("thr byte0", 16'h0033, {8'h00, sink.mem[0]});
        check("thr byte1", 16'h0010, {8'h00, sink.mem[1]});
        check("thr last", 16'h0000, {8'h00, sink.mem[511]});
        slow <= 1'b0;
        run(`SUB_RD_ATTR, `OP_PREDICT, 1'b1);
        check("attr byte1", 16'h0005, {8'h00, sink.mem[1]});
        check("end status", 16'h0000, {8'h00, st & 8'h89});
    endtask : t_blocks
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        {rst_n_i, sample_valid_i, nv_predict_i, nv_autosave_i, clr, slow} = '0;
        host = '0;
        pwr_mode_i = PWR_ACTIVE;
        sample_idx_i = 5'h00;
        sample_val_i = 8'h00;
        thresh_i = '0;
        n_fail = 0;
        samples_checked = 0;
        reset_dev(1'b0, 1'b0);
        wr(`OFF_DRIVE_HEAD, 8'h00);
        t_power();
        t_enable();
        t_settings();
        t_status();
        t_blocks();
        reset_dev(1'b1, 1'b1);
        check("kept settings", 16'h0003, {14'h0, nv_predict_o, nv_autosave_o});
        final_report();
    end
endmodule : tb
